// ==== logic/dts_top.sv ====
/*
 Down transfer sequencer: moves a line-fed motor onto the drive output,
 handshaking with an external contactor controller.
 Assumes controller pins are asynchronous; measurement inputs come from
 logic on CLK_IN.
*/
`timescale 1ns/1ps
`include "dts_consts.svh"
module dts_top #(
  parameter int TICK_CYC = `DTS_TICK_CYC
) (
  // clock and reset
  input  wire logic                  CLK_IN,
  input  wire logic                  RST_N_IN,
  // avalon slave
  input  wire logic [3:0]            AVS_ADDRESS_IN,
  input  wire logic                  AVS_READ_IN,
  input  wire logic                  AVS_WRITE_IN,
  input  wire logic [31:0]           AVS_WRITEDATA_IN,
  input  wire logic [3:0]            AVS_BYTEENABLE_IN,
  output logic      [31:0]           AVS_READDATA_OUT,
  output logic                       AVS_WAITREQUEST_OUT,
  // controller handshake inputs
  input  wire logic                  RUN_REQ_IN,
  input  wire logic                  DOWN_XFER_REQ_IN,
  input  wire logic                  LINE_CTR_ACK_IN,
  input  wire logic                  DRIVE_CTR_ACK_IN,
  input  wire logic                  ESTOP_INHIBIT_IN,
  input  wire logic                  FAULT_IN,
  // drive measurements
  input  wire logic [15:0]           AVAIL_VOLT_IN,
  input  wire logic [15:0]           LINE_VOLT_IN,
  input  wire logic                  PLL_STABLE_IN,
  input  wire logic                  FREQ_MATCH_IN,
  input  wire logic [15:0]           IQ_IN,
  input  wire logic [15:0]           IQ_MAX_IN,
  // controller handshake outputs
  output logic                       DOWN_XFER_PERMIT_OUT,
  output logic                       LINE_CTR_RELEASE_OUT,
  output logic                       DOWN_XFER_DONE_OUT,
  output logic                       LOW_OUTPUT_VOLTAGE_FLAG_OUT,
  output logic                       XFER_FAIL_OUT,
  // drive control
  output logic                       GATE_ENABLE_OUT,
  output logic                       TORQUE_RAMP_OUT,
  output logic                       FOLLOW_SETPOINT_OUT,
  output dts_pkg::dts_code_t         XFER_STATE_OUT
);
  import dts_pkg::*;

  typedef struct packed {
    logic [5:0]  sa;
    logic [5:0]  sb;
    logic [5:0]  sq;
    dts_drv_e    drv;
    dts_xs_e     xs;
    logic        gate;
    logic        ramp;
    logic [2:0]  hs_want;
    logic [2:0]  hs;
    logic [8:0]  gap;
    logic [12:0] dwell;
    logic [25:0] tmo;
    logic        fail;
    logic        fault;
    logic        lowv;
  } dts_top_s;

  dts_top_s    s_ff;
  dts_top_s    nxt_s;
  logic [1:0]  rst_sync_ff;
  logic        rst_n;
  logic        tick;
  logic        spin_en;
  dts_sec_t    timeout_s;
  logic        fault_clr;
  logic        xfer_clr;
  logic [31:0] status;
  logic [2:0]  hs_diff;
  logic        run_s;
  logic        dreq_s;
  logic        lack_s;
  logic        dack_s;
  logic        estop_s;
  logic        iq_ok;
  logic [25:0] tmo_lim;
  logic        can_start;

  // reset assert is immediate, release passes two flops
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  dts_tick #(
    .CYC(TICK_CYC)
  ) u_tick (
    .clk_in   (CLK_IN),
    .rst_n_in (rst_n),
    .tick_out (tick)
  );

  dts_regs u_regs (
    .clk_in          (CLK_IN),
    .rst_n_in        (rst_n),
    .address_in      (AVS_ADDRESS_IN),
    .read_in         (AVS_READ_IN),
    .write_in        (AVS_WRITE_IN),
    .writedata_in    (AVS_WRITEDATA_IN),
    .byteenable_in   (AVS_BYTEENABLE_IN),
    .readdata_out    (AVS_READDATA_OUT),
    .waitrequest_out (AVS_WAITREQUEST_OUT),
    .status_in       (status),
    .spin_en_out     (spin_en),
    .timeout_s_out   (timeout_s),
    .fault_clr_out   (fault_clr),
    .xfer_clr_out    (xfer_clr)
  );

  assign run_s   = s_ff.sb[`DTS_PIN_RUN];
  assign dreq_s  = s_ff.sb[`DTS_PIN_DREQ];
  assign lack_s  = s_ff.sb[`DTS_PIN_LACK];
  assign dack_s  = s_ff.sb[`DTS_PIN_DACK];
  assign estop_s = s_ff.sb[`DTS_PIN_ESTOP];
  // quarter of max compared as 4*iq >= max, no divider needed
  assign iq_ok   = {IQ_IN, 2'h0} >= {2'h0, IQ_MAX_IN}; // see (R9)
  assign tmo_lim = 26'(timeout_s) * 26'(`DTS_SEC_TICKS); // see (R23)
  assign hs_diff = s_ff.hs ^ s_ff.hs_want;
  assign can_start = run_s && !s_ff.sq[`DTS_PIN_RUN] && dreq_s && lack_s
                  && spin_en && !s_ff.fail && !s_ff.fault && !estop_s;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.sa = {FAULT_IN, ESTOP_INHIBIT_IN, DRIVE_CTR_ACK_IN,
                LINE_CTR_ACK_IN, DOWN_XFER_REQ_IN, RUN_REQ_IN};
    nxt_s.sb = s_ff.sa;
    nxt_s.sq = s_ff.sb;
    if (s_ff.sb[`DTS_PIN_FAULT]) begin
      nxt_s.fault = 1'b1; // see (R17)
    end else if (fault_clr) begin
      nxt_s.fault = 1'b0;
    end
    if (xfer_clr) begin
      nxt_s.fail = 1'b0;
    end
    // one handshake edge at a time, spaced by the gap timer
    if (s_ff.gap != 9'h000) begin
      if (tick) begin
        nxt_s.gap = s_ff.gap - 9'h001;
      end
    end else if (hs_diff != 3'h0) begin
      nxt_s.hs  = s_ff.hs ^ (hs_diff & 3'(~hs_diff + 3'h1)); // see (R21)
      nxt_s.gap = 9'(`DTS_GAP_TICKS);
    end
    if (s_ff.drv == DRV_DOWN && s_ff.xs != XS_DONE && tick) begin
      nxt_s.tmo = s_ff.tmo + 26'h0000001;
    end
    unique case (s_ff.drv)
      DRV_IDLE: begin
        if (!run_s) begin
          nxt_s.lowv = 1'b0;
        end
        if (can_start) begin // see (R1)
          if (AVAIL_VOLT_IN < LINE_VOLT_IN) begin
            nxt_s.lowv = 1'b1; // see (R4)
          end else begin
            nxt_s.lowv = 1'b0;
            nxt_s.hs_want[`DTS_HS_PERMIT] = 1'b1; // see (R3)
            nxt_s.drv   = DRV_DOWN;
            nxt_s.xs    = XS_INIT; // see (R6)
            nxt_s.dwell = 13'h0000;
            nxt_s.tmo   = 26'h0000000;
          end
        end
      end
      DRV_DOWN: begin
        unique case (s_ff.xs)
          XS_INIT: begin
            if (!dack_s) begin
              nxt_s.dwell = 13'h0000;
            end else if (tick && s_ff.dwell < 13'(`DTS_PLL_TICKS)) begin
              nxt_s.dwell = s_ff.dwell + 13'h0001; // see (R22)
            end
            if (dack_s && s_ff.dwell >= 13'(`DTS_PLL_TICKS)
                && PLL_STABLE_IN) begin
              nxt_s.xs    = XS_FLOCK; // see (R6)
              nxt_s.gate  = 1'b1; // see (R7)
              nxt_s.dwell = 13'h0000;
            end
          end
          XS_FLOCK: begin
            if (!FREQ_MATCH_IN) begin
              nxt_s.dwell = 13'h0000; // see (R8)
            end else if (tick) begin
              nxt_s.dwell = s_ff.dwell + 13'h0001;
            end
            if (FREQ_MATCH_IN
                && s_ff.dwell >= 13'(`DTS_LOCK_TICKS)) begin
              nxt_s.xs    = XS_TORQ; // see (R8)
              nxt_s.ramp  = 1'b1;
              nxt_s.dwell = 13'h0000;
            end
          end
          XS_TORQ: begin
            if (iq_ok) begin
              nxt_s.xs = XS_OPEN; // see (R9)
              nxt_s.hs_want[`DTS_HS_RELEASE] = 1'b1; // see (R10)
            end
          end
          XS_OPEN: begin
            if (!lack_s && s_ff.sq[`DTS_PIN_LACK]) begin
              nxt_s.xs = XS_DONE; // see (R12)
              nxt_s.hs_want[`DTS_HS_DONE] = 1'b1; // see (R13)
            end
          end
          XS_DONE: begin
            if (!dreq_s) begin
              nxt_s.hs_want = 3'h0; // see (R13)
              nxt_s.drv  = DRV_RUN; // see (R14)
              nxt_s.xs   = XS_INIT;
              nxt_s.ramp = 1'b0;
            end
          end
        endcase
        // waits of the transfer before complete are bounded by a nonzero timeout
        if (s_ff.xs != XS_DONE && timeout_s != 16'h0000
            && s_ff.tmo >= tmo_lim) begin
          nxt_s.fail    = 1'b1; // see (R15)
          nxt_s.xs      = XS_INIT;
          nxt_s.drv     = DRV_IDLE;
          nxt_s.gate    = 1'b0;
          nxt_s.ramp    = 1'b0;
          nxt_s.hs_want = 3'h0;
        end
      end
      DRV_RUN: begin
        nxt_s.xs = XS_INIT; // see (R14)
      end
    endcase
    // stop, fault and inhibit all coast the output off at once
    if (s_ff.drv != DRV_IDLE
        && (!run_s || s_ff.fault || estop_s)) begin
      nxt_s.drv     = DRV_IDLE; // see (R16) (R17) (R19)
      nxt_s.xs      = XS_INIT;
      nxt_s.gate    = 1'b0;
      nxt_s.ramp    = 1'b0;
      nxt_s.hs_want = 3'h0;
      nxt_s.dwell   = 13'h0000;
    end
  end

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      s_ff     <= '0;
      s_ff.drv <= DRV_IDLE;
      s_ff.xs  <= XS_INIT;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign status = {17'h00000, s_ff.gate, s_ff.fault, s_ff.fail, s_ff.lowv,
                   s_ff.hs, 2'h0, 2'(s_ff.drv), 1'b0,
                   dts_xs_code(s_ff.xs)};
  assign DOWN_XFER_PERMIT_OUT        = s_ff.hs[`DTS_HS_PERMIT];
  assign LINE_CTR_RELEASE_OUT        = s_ff.hs[`DTS_HS_RELEASE];
  assign DOWN_XFER_DONE_OUT          = s_ff.hs[`DTS_HS_DONE];
  assign LOW_OUTPUT_VOLTAGE_FLAG_OUT = s_ff.lowv;
  assign XFER_FAIL_OUT               = s_ff.fail;
  assign GATE_ENABLE_OUT             = s_ff.gate;
  assign TORQUE_RAMP_OUT             = s_ff.ramp;
  assign FOLLOW_SETPOINT_OUT         = s_ff.drv == DRV_RUN;
  assign XFER_STATE_OUT              = dts_xs_code(s_ff.xs); // see (R5)

  default clocking dts_cb @(posedge CLK_IN);
  endclocking
  default disable iff (!rst_n);

  entry_guard_a: assert property ( // see (R1)
    (s_ff.drv == DRV_DOWN && $past(s_ff.drv) == DRV_IDLE)
      |-> $past(lack_s && dreq_s && spin_en && !s_ff.fail))
    else $error("transfer entered without its preconditions");
  low_volt_a: assert property ( // see (R4)
    $rose(s_ff.lowv) |-> s_ff.drv == DRV_IDLE
      && $past(AVAIL_VOLT_IN < LINE_VOLT_IN))
    else $error("low voltage flag without refused entry");
  state_code_a: assert property ( // see (R5)
    s_ff.xs == XS_OPEN |-> XFER_STATE_OUT == 3'h5)
    else $error("wrong code for contactor opening wait");
  gate_step_a: assert property ( // see (R7)
    $rose(s_ff.gate) |-> s_ff.xs == XS_FLOCK && $past(s_ff.xs) == XS_INIT)
    else $error("gates enabled outside init to lock step");
  lock_dwell_a: assert property ( // see (R8)
    (s_ff.xs == XS_TORQ && $past(s_ff.xs) == XS_FLOCK)
      |-> $past(s_ff.dwell) >= 13'(`DTS_LOCK_TICKS))
    else $error("torque build before one second of lock");
  torque_done_a: assert property ( // see (R9)
    (s_ff.xs == XS_OPEN && $past(s_ff.xs) == XS_TORQ) |-> $past(iq_ok)
      && s_ff.hs_want[`DTS_HS_RELEASE])
    else $error("contactor wait without torque current");
  open_done_a: assert property ( // see (R12)
    (s_ff.xs == XS_DONE && $past(s_ff.xs) == XS_OPEN)
      |-> $past(!lack_s && s_ff.sq[`DTS_PIN_LACK]))
    else $error("complete without line ack falling");
  timeout_init_a: assert property ( // see (R15)
    $rose(s_ff.fail) |-> s_ff.xs == XS_INIT && s_ff.drv == DRV_IDLE)
    else $error("timeout did not return to init");
  stop_off_a: assert property ( // see (R16)
    (s_ff.drv != DRV_IDLE && !run_s) |=> !s_ff.gate ##1 !s_ff.gate)
    else $error("output not disabled on stop");
  fault_block_a: assert property ( // see (R17) (R19)
    (s_ff.fault || estop_s) |=> s_ff.drv == DRV_IDLE || !$past(s_ff.gate))
    else $error("running while fault or inhibit active");
  hs_single_a: assert property ( // see (R21)
    $changed(s_ff.hs) |-> $onehot(s_ff.hs ^ $past(s_ff.hs))
      && $past(s_ff.gap) == 9'h000)
    else $error("handshake outputs changed too close or together");
endmodule

// ==== common/dts_consts.svh ====
/*
 Constants of the down transfer sequencer: register map, field positions,
 reset values and timing counts.
 Assumes a 25 MHz system clock and a 1 ms time base made from it.
*/
// Notes on behaviour
// (R1) transfer starts only from idle, on line, line ack set, spin capture on.
// (R2) controller raises transfer request before its run request.
// (R3) run request with transfer request raises permit, then enters transfer.
// (R4) output voltage below line voltage refuses entry and raises low-voltage flag.
// (R5) transfer state codes: init 0, lock 1, torque 3, open 5, done 6.
// (R6) start in init, go to frequency lock once output loop is stable.
// (R7) output switching enabled exactly on init to frequency lock step.
// (R8) frequencies within half hertz for one continuous second before torque build.
// (R9) ramp torque; leave at torque current of at least a quarter of max.
// (R10) entering contactor-opening wait drives line contactor release true.
// (R11) controller drops line ack only after line contactor confirmed open.
// (R12) falling line ack during contactor-opening wait moves to complete.
// (R13) complete raises done; done cleared after request removed.
// (R14) after completion follow the speed setpoint; machine back to init.
// (R15) timeout returns to init, warns, blocks new transfers until reset.
// (R16) run request removal disables output at once; controller then unwinds.
// (R17) fault coasts to idle; running blocked until fault reset.
// (R18) controller opens drive contactor, drops ack and request after fault.
// (R19) inhibit acts like fault without reset; running resumes once cleared.
// (R20) controller owns both contactors, closes drive contactor on permit.
// (R21) handshake changes at least 250 ms apart, never two together.
// (R22) wait five seconds after drive contactor ack before lock.
// (R23) timers count a fixed tick, timeout configurable, cleared on state change; the timeout count here runs from entry and is not cleared between states.
`ifndef DTS_CONSTS_SVH
`define DTS_CONSTS_SVH

`define DTS_CLK_HZ       25000000
`define DTS_TICK_US      1000
`define DTS_TICK_CYC     (`DTS_CLK_HZ / 1000000 * `DTS_TICK_US)
`define DTS_GAP_MS       250
`define DTS_LOCK_S       1
`define DTS_PLL_S        5
`define DTS_GAP_TICKS    (`DTS_GAP_MS * 1000 / `DTS_TICK_US)
`define DTS_SEC_TICKS    (1000000 / `DTS_TICK_US)
`define DTS_LOCK_TICKS   (`DTS_LOCK_S * `DTS_SEC_TICKS)
`define DTS_PLL_TICKS    (`DTS_PLL_S * `DTS_SEC_TICKS)

`define DTS_REG_CTRL     2'h0
`define DTS_REG_TIMEOUT  2'h1
`define DTS_REG_STATUS   2'h2
`define DTS_CTRL_SPIN    0
`define DTS_CTRL_FCLR    8
`define DTS_CTRL_XCLR    9
`define DTS_SPIN_RST     1'h0
`define DTS_TIMEOUT_RST  16'h001E

`define DTS_ST_DRV       4
`define DTS_ST_PERMIT    8
`define DTS_ST_RELEASE   9
`define DTS_ST_DONE      10
`define DTS_ST_LOWV      11
`define DTS_ST_FAIL      12
`define DTS_ST_FAULT     13
`define DTS_ST_GATE      14

`define DTS_HS_PERMIT    0
`define DTS_HS_RELEASE   1
`define DTS_HS_DONE      2
`define DTS_PIN_RUN      0
`define DTS_PIN_DREQ     1
`define DTS_PIN_LACK     2
`define DTS_PIN_DACK     3
`define DTS_PIN_ESTOP    4
`define DTS_PIN_FAULT    5

`endif

// ==== common/dts_pkg.sv ====
/*
 Types of the down transfer sequencer: drive and transfer state enums and
 the mapping of transfer states to their plotted codes.
 Assumes dts_consts.svh is on the include path.
*/
package dts_pkg;
  typedef logic [15:0] dts_sec_t;
  typedef logic [2:0]  dts_code_t;
  typedef enum logic [1:0] {DRV_IDLE, DRV_DOWN, DRV_RUN} dts_drv_e;
  typedef enum logic [2:0] {
    XS_INIT, XS_FLOCK, XS_TORQ, XS_OPEN, XS_DONE
  } dts_xs_e;

  function automatic dts_code_t dts_xs_code(input dts_xs_e xs);
    unique case (xs)
      XS_INIT:  dts_xs_code = 3'h0;
      XS_FLOCK: dts_xs_code = 3'h1;
      XS_TORQ:  dts_xs_code = 3'h3;
      XS_OPEN:  dts_xs_code = 3'h5;
      XS_DONE:  dts_xs_code = 3'h6;
      default:  dts_xs_code = 3'h0;
    endcase
  endfunction
endpackage

// ==== logic/dts_tick.sv ====
/*
 Time base: one-cycle enable pulse every CYC clocks.
 Assumes an active-low reset from the top, asserted at once and released in step with the clock.
*/
`timescale 1ns/1ps
module dts_tick #(
  parameter int CYC = 25000
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // time base
  output logic      tick_out
);
  typedef struct packed {
    logic [23:0] cnt;
    logic        tick;
  } dts_tick_s;

  dts_tick_s s_ff;
  dts_tick_s nxt_s;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.tick = 1'b0;
    if (s_ff.cnt == 24'(CYC - 1)) begin
      nxt_s.cnt  = 24'h000000;
      nxt_s.tick = 1'b1;
    end else begin
      nxt_s.cnt = s_ff.cnt + 24'h000001;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign tick_out = s_ff.tick;
endmodule

// ==== logic/dts_regs.sv ====
/*
 Avalon-MM slave with one wait state: control, timeout and status words.
 Assumes byte addresses; bits [1:0] of the address are ignored.
*/
`timescale 1ns/1ps
`include "dts_consts.svh"
module dts_regs (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // avalon slave
  input  wire logic [3:0]       address_in,
  input  wire logic             read_in,
  input  wire logic             write_in,
  input  wire logic [31:0]      writedata_in,
  input  wire logic [3:0]       byteenable_in,
  output logic      [31:0]      readdata_out,
  output logic                  waitrequest_out,
  // block side
  input  wire logic [31:0]      status_in,
  output logic                  spin_en_out,
  output dts_pkg::dts_sec_t     timeout_s_out,
  output logic                  fault_clr_out,
  output logic                  xfer_clr_out
);
  import dts_pkg::*;

  typedef struct packed {
    logic        ack;
    logic        spin;
    dts_sec_t    tmo;
    logic [31:0] rdata;
    logic        fclr;
    logic        xclr;
  } dts_regs_s;

  dts_regs_s s_ff;
  dts_regs_s nxt_s;
  logic      req;
  logic [1:0] idx;

  assign req = read_in | write_in;
  assign idx = address_in[3:2];

  always_comb begin
    nxt_s = s_ff;
    nxt_s.fclr = 1'b0;
    nxt_s.xclr = 1'b0;
    nxt_s.ack  = req & ~s_ff.ack;
    // read data settle during the wait state, ready at the accepting edge
    if (read_in && !s_ff.ack) begin
      unique case (idx)
        `DTS_REG_CTRL:    nxt_s.rdata = {31'h00000000, s_ff.spin};
        `DTS_REG_TIMEOUT: nxt_s.rdata = {16'h0000, s_ff.tmo};
        `DTS_REG_STATUS:  nxt_s.rdata = status_in;
        default:          nxt_s.rdata = 32'h00000000;
      endcase
    end
    if (write_in && s_ff.ack) begin
      if (idx == `DTS_REG_CTRL && byteenable_in[0]) begin
        nxt_s.spin = writedata_in[`DTS_CTRL_SPIN];
      end
      if (idx == `DTS_REG_CTRL && byteenable_in[1]) begin
        nxt_s.fclr = writedata_in[`DTS_CTRL_FCLR];
        nxt_s.xclr = writedata_in[`DTS_CTRL_XCLR];
      end
      if (idx == `DTS_REG_TIMEOUT && byteenable_in[0]) begin
        nxt_s.tmo[7:0] = writedata_in[7:0];
      end
      if (idx == `DTS_REG_TIMEOUT && byteenable_in[1]) begin
        nxt_s.tmo[15:8] = writedata_in[15:8];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_ff      <= '0;
      s_ff.spin <= `DTS_SPIN_RST;
      s_ff.tmo  <= `DTS_TIMEOUT_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign waitrequest_out = req & ~s_ff.ack;
  assign readdata_out    = s_ff.rdata;
  assign spin_en_out     = s_ff.spin;
  assign timeout_s_out   = s_ff.tmo;
  assign fault_clr_out   = s_ff.fclr;
  assign xfer_clr_out    = s_ff.xclr;
endmodule

// ==== bench/dts_plc_model.sv ====
/*
 Contactor controller model: closes and opens the line and drive
 contactors around a down transfer, one change per gap, or per two gaps while slow_in is high.
 Assumes the bench drives sel_in high while the motor is selected.
*/
`timescale 1ns/1ps
module dts_plc_model #(
  parameter int GAP = 520
) (
  // clock
  input  wire logic clk_in,
  // commands and device flags
  input  wire logic sel_in,
  input  wire logic slow_in,
  input  wire logic permit_in,
  input  wire logic release_in,
  // contactor acknowledges
  output logic      line_ack_out,
  output logic      drive_ack_out
);
  int   cnt = 0;
  logic seen = 1'b0;
  initial begin
    line_ack_out = 1'b0;
    drive_ack_out = 1'b0;
  end
  // every contactor change restarts the gap count
  always @(posedge clk_in) begin
    cnt <= cnt + 1;
    if (cnt < (slow_in ? 2 * GAP : GAP)) begin
    end else if (sel_in && !seen) begin
      line_ack_out <= 1'b1;  // motor starts on the line
      seen <= 1'b1;
      cnt <= 0;
    end else if (!sel_in && drive_ack_out) begin
      drive_ack_out <= 1'b0;  // unwind drive side first
      cnt <= 0;
    end else if (!sel_in && seen) begin
      line_ack_out <= 1'b0;
      seen <= 1'b0;
      cnt <= 0;
    end else if (sel_in && permit_in && !drive_ack_out) begin
      drive_ack_out <= 1'b1;  // close drive contactor on permit
      cnt <= 0;
    end else if (sel_in && release_in && line_ack_out) begin
      line_ack_out <= 1'b0;  // only once confirmed open
      cnt <= 0;
    end
  end
endmodule

// ==== bench/testbench.sv ====
/*
 Bench for the down transfer sequencer: register access and whole
 transfers against the contactor controller model.
 Assumes a 2-cycle tick, so 1 ms is 2 clocks.
*/
`timescale 1ns/1ps
module testbench;
  import dts_pkg::*;
  localparam int GAP = 520;
  logic        clk, rst_n, rd, wr, run, req, estop, flt, fm, sel, slow;
  logic [3:0]  adr;
  logic [31:0] wd, q;
  logic [15:0] av, iq;
  wire  [31:0] rdat;
  wire         wrq, lack;
  wire  [8:0]  obs;
  dts_code_t   st;
  int          miscompares = 0;
  int          checks_done = 0;
  int          n;
  // obs: gate, permit, release, done, low volt, fail, follow, ramp, dack
  dts_top #(.TICK_CYC(2)) i_dts_top (
    .CLK_IN(clk), .RST_N_IN(rst_n), .AVS_ADDRESS_IN(adr),
    .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd),
    .AVS_BYTEENABLE_IN(4'hF), .AVS_READDATA_OUT(rdat),
    .AVS_WAITREQUEST_OUT(wrq), .RUN_REQ_IN(run), .DOWN_XFER_REQ_IN(req),
    .LINE_CTR_ACK_IN(lack), .DRIVE_CTR_ACK_IN(obs[8]),
    .ESTOP_INHIBIT_IN(estop), .FAULT_IN(flt), .AVAIL_VOLT_IN(av),
    .LINE_VOLT_IN(16'h1000), .PLL_STABLE_IN(1'b1), .FREQ_MATCH_IN(fm),
    .IQ_IN(iq), .IQ_MAX_IN(16'h0190), .DOWN_XFER_PERMIT_OUT(obs[1]),
    .LINE_CTR_RELEASE_OUT(obs[2]), .DOWN_XFER_DONE_OUT(obs[3]),
    .LOW_OUTPUT_VOLTAGE_FLAG_OUT(obs[4]), .XFER_FAIL_OUT(obs[5]),
    .GATE_ENABLE_OUT(obs[0]), .TORQUE_RAMP_OUT(obs[7]),
    .FOLLOW_SETPOINT_OUT(obs[6]), .XFER_STATE_OUT(st));
  dts_plc_model #(.GAP(GAP)) i_dts_plc_model (.clk_in(clk), .sel_in(sel),
    .slow_in(slow), .permit_in(obs[1]), .release_in(obs[2]),
    .line_ack_out(lack), .drive_ack_out(obs[8]));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task close_out();
    if (miscompares == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
      miscompares++;
    end
  endtask
  task hang(input string nm);
    $display("CHECK FAILED %s expected answer seen none", nm);
    miscompares++;
    close_out();
  endtask
  task pause(input int k);
    repeat (k * GAP) @(posedge clk);
  endtask
  // bounded wait for an observed output; n returns the cycles taken
  task await(input int b, input logic v, input int lim);
    n = 0;
    while (obs[b] !== v) begin
      @(posedge clk);
      n++;
      if (n > lim) hang("output wait");
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    adr <= a;
    rd <= !w;
    wr <= w;
    wd <= d;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (wrq !== 1'b0 && k < 50);
    if (wrq !== 1'b0) hang("waitrequest");
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task rchk(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("register", e, q);
  endtask
  // controller order: line ack, request, then run
  task start();
    sel <= 1'b1;
    pause(2);
    req <= 1'b1;
    pause(1);
    run <= 1'b1;
  endtask
  task stop_all();
    run <= 1'b0;
    pause(1);
    sel <= 1'b0;
    pause(3);
    req <= 1'b0;
    pause(1);
  endtask
  task rerun();
    run <= 1'b0;
    pause(1);
    run <= 1'b1;
  endtask
  initial begin
    rst_n = 1'b0;
    {adr, rd, wr, wd, run, req, estop, flt, fm, sel, slow} = '0;
    av = 16'h1000;
    iq = 16'h0000;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rchk(4'h0, 32'h0);
    rchk(4'h4, 32'h1E);
    bus(1'b1, 4'hC, 32'hFFFFFFFF);
    rchk(4'hC, 32'h0);
    bus(1'b1, 4'h0, 32'h1);
    rchk(4'h0, 32'h1);
    // output capability one step below line voltage
    av <= 16'h0FFF;
    start();
    await(4, 1'b1, 3000);
    chk("permit", 0, obs[1]);
    chk("state", 0, st);
    stop_all();
    av <= 16'h1000;
    start();
    await(1, 1'b1, 3000);
    await(8, 1'b1, 3000);
    await(0, 1'b1, 12000);
    chk("pll wait", 1, n >= 9995);
    chk("state", 1, st);
    // a dropout in the match must restart the one second
    fm <= 1'b1;
    repeat (1000) @(posedge clk);
    fm <= 1'b0;
    repeat (4) @(posedge clk);
    fm <= 1'b1;
    await(7, 1'b1, 3000);
    chk("lock time", 1, n >= 1998 && n <= 2100);
    chk("state", 3, st);
    iq <= 16'h0063;
    repeat (200) @(posedge clk);
    chk("state", 3, st);
    iq <= 16'h0064;
    await(2, 1'b1, 1000);
    chk("state", 5, st);
    await(3, 1'b1, 3000);
    chk("state", 6, st);
    pause(1);
    req <= 1'b0;
    await(3, 1'b0, 3000);
    await(6, 1'b1, 3000);
    chk("state", 0, st);
    run <= 1'b0;
    repeat (8) @(posedge clk);
    chk("gate", 0, obs[0]);
    pause(1);
    sel <= 1'b0;
    pause(3);
    // one second timeout inside the five second pll wait, frequency never matching
    fm <= 1'b0;
    bus(1'b1, 4'h4, 32'h1);
    start();
    await(5, 1'b1, 6000);
    chk("state", 0, st);
    rerun();
    pause(1);
    chk("permit", 0, obs[1]);
    bus(1'b1, 4'h0, 32'h201);
    rchk(4'h8, 32'h0);
    bus(1'b0, 4'h8, 32'h0);
    chk("fail", 0, q[12]);
    rerun();
    await(1, 1'b1, 3000);
    stop_all();
    bus(1'b1, 4'h4, 32'h1E);
    start();
    await(0, 1'b1, 16000);
    flt <= 1'b1;
    repeat (8) @(posedge clk);
    chk("gate", 0, obs[0]);
    chk("state", 0, st);
    flt <= 1'b0;
    rerun();
    pause(1);
    chk("permit", 0, obs[1]);
    // controller unwinds both contactors and the request before restart
    stop_all();
    bus(1'b1, 4'h0, 32'h101);
    start();
    await(1, 1'b1, 3000);
    slow <= 1'b1;
    await(0, 1'b1, 16000);
    estop <= 1'b1;
    repeat (8) @(posedge clk);
    chk("gate", 0, obs[0]);
    estop <= 1'b0;
    rerun();
    await(1, 1'b1, 3000);
    stop_all();
    close_out();
  end
endmodule
